// file: pkg/fer_cfg.svh
// constants of the event record encoder
`ifndef FER_CFG_SVH
`define FER_CFG_SVH
`define FER_ID_DEBUG     8'hF5
`define FER_META_FLUSH   8'h01
`define FER_META_RATE    8'h02
`define FER_META_OVF     8'h0C
`define FER_META_DYNR    8'h0D
`define FER_META_INIT    8'h10
`define FER_DBG_MAX      4'hC
`define FER_DBG_FMT_BIT  6
`define FER_ACT_END_LSB  0
`define FER_ACT_BEG_LSB  8
`define FER_META_LEN     4'h4
`define FER_ACT_LEN      4'h3
`define FER_RNG_ACC      16'h0004
`define FER_RNG_GYR      16'h07D0
`define FER_RNG_MAG      16'h03E8
`define FER_CNT_MAX      16'hFFFF
`endif

// file: pkg/fer_pkg.sv
// types of the event record encoder
package fer_pkg;
   typedef logic [7:0]        fer_byte_t;
   typedef fer_byte_t [13:0]  fer_rec_t;
   typedef logic [15:0]       fer_rng_t;
   typedef fer_rng_t [2:0]    fer_rng3_t;
   typedef enum logic [1:0] {
      FER_ST_IDLE = 2'b00,
      FER_ST_LOAD = 2'b01,
      FER_ST_SEND = 2'b11
   } fer_state_t;
   typedef enum logic [2:0] {
      FER_K_INIT = 3'h0,
      FER_K_OVF  = 3'h1,
      FER_K_FLSH = 3'h2,
      FER_K_RATE = 3'h3,
      FER_K_DYNR = 3'h4,
      FER_K_ACT  = 3'h5,
      FER_K_DBG  = 3'h6
   } fer_kind_t;
endpackage

// file: pkg/fer_rec_if.sv
// record hand-off between picker and byte sender
`timescale 1ns/1ps
interface fer_rec_if;
   import fer_pkg::*;
   logic      load;
   logic [3:0] len;
   fer_rec_t  bytes;
   logic      wake;
   logic      busy;
   modport src (output load, output len, output bytes, output wake, input busy);
   modport snk (input load, input len, input bytes, input wake, output busy);
endinterface

// file: verification/fer_fifo_sink.sv
// host side fifo reader model for the record stream
`timescale 1ns/1ps
module fer_fifo_sink (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               slow,
   input  wire logic               hold,
   input  wire fer_pkg::fer_byte_t fifo_data,
   input  wire logic               fifo_valid,
   input  wire logic               fifo_first,
   input  wire logic               fifo_last,
   input  wire logic               fifo_wake,
   output logic                    fifo_ready
);
   import fer_pkg::*;
   logic [15:0] lfsr_r;
   logic        in_rec_r;
   fer_byte_t   got[$];
   logic        wk[$];
   int          bad = 0;
   // ready answers promptly, slowly at random, or stalls on hold
   always @(posedge clk_sys) begin
      if (rst) begin
         lfsr_r <= 16'hACE1;
         in_rec_r <= 1'b0;
         fifo_ready <= 1'b0;
      end else begin
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
         fifo_ready <= !hold && (!slow || lfsr_r[0]);
         if (fifo_valid && fifo_ready) begin
            got.push_back(fifo_data);
            if (fifo_first) begin
               wk.push_back(fifo_wake);
            end
            if (fifo_first === in_rec_r) begin
               bad++;
            end
            in_rec_r <= !fifo_last;
         end
      end
   end
endmodule

// file: verification/tb_fifo_event_record_encoder.sv
// self-checking bench of the event record encoder
`timescale 1ns/1ps
`include "fer_cfg.svh"
module tb_fifo_event_record_encoder;
   import fer_pkg::*;
   localparam fer_byte_t META_ID = 8'hFE;
   localparam fer_byte_t ACT_ID  = 8'h1F;
   logic        clk_sys = 0, rst = 1, slow = 0, hold = 0;
   logic [15:0] ram_ver = 0;
   logic [16:0] meta_en = 0, meta_int_en = 0;
   logic        act_valid = 0, dbg_valid = 0, dbg_last = 0, dbg_bin = 0;
   logic [5:0]  act_end = 0, act_start = 0, rng_active = 0;
   fer_byte_t   dbg_byte = 0, flush_sensor = 0, rate_sensor = 0, ovf_bytes = 0;
   logic        flush_req = 0, flush_wake = 0, rate_chg = 0, ovf_valid = 0;
   fer_rng_t    rng_val [6] = '{default: 16'h0000};
   fer_rng3_t   scale_rng_r;
   fer_byte_t   fifo_data_r;
   logic        dbg_ready_r, fifo_ready, fifo_valid_r, fifo_first_r, fifo_last_r, fifo_wake_r;
   logic        host_irq_r, init_done_r, flush_xfer_r;
   fer_byte_t   exp_q[$];
   logic        exp_wk[$];
   int          errors = 0, checks = 0, irqs = 0, xfers = 0, cyc = 0;
   fer_byte_t   s, a, b;
   fer_rng_t    r0, r1;

   fer_encoder #(.NV(2), .META_ID(META_ID), .ACT_ID(ACT_ID)) fer_encoder_i (
      .clk_sys(clk_sys), .rst(rst), .ram_ver(ram_ver), .meta_en(meta_en), .meta_int_en(meta_int_en),
      .act_valid(act_valid), .act_end(act_end), .act_start(act_start), .dbg_valid(dbg_valid),
      .dbg_byte(dbg_byte), .dbg_last(dbg_last), .dbg_bin(dbg_bin), .dbg_ready_r(dbg_ready_r),
      .flush_req(flush_req), .flush_sensor(flush_sensor), .flush_wake(flush_wake), .rate_chg(rate_chg),
      .rate_sensor(rate_sensor), .ovf_valid(ovf_valid), .ovf_bytes(ovf_bytes), .rng_active(rng_active),
      .rng_val(rng_val), .scale_rng_r(scale_rng_r), .fifo_ready(fifo_ready), .fifo_data_r(fifo_data_r),
      .fifo_valid_r(fifo_valid_r), .fifo_first_r(fifo_first_r), .fifo_last_r(fifo_last_r),
      .fifo_wake_r(fifo_wake_r), .host_irq_r(host_irq_r), .init_done_r(init_done_r),
      .flush_xfer_r(flush_xfer_r));

   fer_fifo_sink fer_fifo_sink_i (
      .clk_sys(clk_sys), .rst(rst), .slow(slow), .hold(hold), .fifo_data(fifo_data_r),
      .fifo_valid(fifo_valid_r), .fifo_first(fifo_first_r), .fifo_last(fifo_last_r),
      .fifo_wake(fifo_wake_r), .fifo_ready(fifo_ready));

   always #12.5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      irqs += int'(host_irq_r === 1'b1);
      xfers += int'(flush_xfer_r === 1'b1);
      cyc++;
      if (cyc == 30000) begin
         errors++;
         test_done();
      end
   end

   task automatic chk(string name, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic void rec(fer_byte_t id, fer_byte_t b0, fer_byte_t b1, fer_byte_t b2, logic w);
      exp_q.push_back(id);
      exp_q.push_back(b0);
      exp_q.push_back(b1);
      if (id == META_ID) exp_q.push_back(b2);
      exp_wk.push_back(w);
   endfunction

   // host scale of one count in 2^-16 units: range over two to fifteen
   function automatic logic [15:0] host_lsb(fer_rng_t r);
      return 16'(({16'h0000, r} << 16) >> 15);
   endfunction

   // waits for the expected bytes, then compares stream and wake flags
   task automatic drain();
      int n;
      n = 0;
      while (fer_fifo_sink_i.got.size() < exp_q.size() && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (30) @(posedge clk_sys);
      chk("byte count", 16'(exp_q.size()), 16'(fer_fifo_sink_i.got.size()));
      foreach (exp_q[i]) if (i < fer_fifo_sink_i.got.size()) chk("byte", exp_q[i], fer_fifo_sink_i.got[i]);
      foreach (exp_wk[i])
         if (exp_wk[i] !== 1'bx && i < fer_fifo_sink_i.wk.size()) chk("wake", exp_wk[i], fer_fifo_sink_i.wk[i]);
      exp_q.delete();
      exp_wk.delete();
      fer_fifo_sink_i.got.delete();
      fer_fifo_sink_i.wk.delete();
   endtask

   task automatic pulse(int k, fer_byte_t v, logic w);
      @(posedge clk_sys);
      flush_req <= (k == 0);
      flush_sensor <= v;
      flush_wake <= w;
      rate_chg <= (k == 1);
      rate_sensor <= v;
      act_valid <= (k == 2);
      @(posedge clk_sys);
      flush_req <= 1'b0;
      rate_chg <= 1'b0;
      act_valid <= 1'b0;
   endtask

   task automatic dbg_send(int n, logic bin);
      fer_byte_t c;
      for (int i = 0; i < n; i++) begin
         if (i % 12 == 0) begin
            exp_q.push_back(`FER_ID_DEBUG);
            exp_q.push_back({1'b0, bin, 6'((n - i > 12) ? 12 : n - i)});
            exp_wk.push_back(1'b0);
         end
         c = 8'(8'h41 + $urandom_range(0, 25));
         exp_q.push_back(c);
         dbg_valid <= 1'b1;
         dbg_byte <= c;
         dbg_bin <= bin;
         dbg_last <= (i == n - 1);
         do @(posedge clk_sys); while (dbg_ready_r !== 1'b1);
      end
      dbg_valid <= 1'b0;
      @(posedge clk_sys);
   endtask

   initial begin
      void'($urandom(32'h0FB4));
      ram_ver = 16'($urandom);
      meta_en = 17'h13006;
      meta_int_en = 17'h00002;
      slow = 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk("acc default", `FER_RNG_ACC, scale_rng_r[0]);
      chk("gyr default", `FER_RNG_GYR, scale_rng_r[1]);
      chk("mag default", `FER_RNG_MAG, scale_rng_r[2]);
      rec(META_ID, `FER_META_INIT, ram_ver[7:0], ram_ver[15:8], 1'bx);
      drain();
      chk("init done", 16'h0001, {15'h0000, init_done_r});
      irqs = 0;
      s = 8'($urandom);
      pulse(0, s, 1'b1);
      rec(META_ID, `FER_META_FLUSH, s, 8'h00, 1'b1);
      drain();
      chk("flush irq", 16'h0001, 16'(irqs));
      chk("flush xfer", 16'h0001, 16'(xfers));
      pulse(1, s + 8'h01, 1'b0);
      rec(META_ID, `FER_META_RATE, s + 8'h01, 8'h00, 1'bx);
      drain();
      chk("rate no irq", 16'h0001, 16'(irqs));
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 8'h00 : 8'($urandom_range(0, 63));
         b = (i == 0) ? 8'h00 : 8'((i == 1) ? 0 : $urandom_range(1, 63));
         act_end <= a[5:0];
         act_start <= b[5:0];
         pulse(2, 8'h00, 1'b0);
         if ((a | b) != 0) rec(ACT_ID, a, b, 8'h00, 1'bx);
         drain();
      end
      dbg_send(20, 1'b0);
      dbg_send(5, 1'b1);
      drain();
      hold <= 1'b1;
      pulse(0, 8'h21, 1'b0);
      while (fifo_valid_r !== 1'b1) @(posedge clk_sys);
      ovf_bytes <= 8'hFF;
      ovf_valid <= 1'b1;
      repeat (300) @(posedge clk_sys);
      ovf_valid <= 1'b0;
      act_end <= 6'h21;
      act_start <= 6'h12;
      pulse(2, 8'h00, 1'b0);
      pulse(1, 8'h22, 1'b0);
      hold <= 1'b0;
      rec(META_ID, `FER_META_FLUSH, 8'h21, 8'h00, 1'b0);
      rec(META_ID, `FER_META_OVF, 8'hFF, 8'hFF, 1'bx);
      rec(META_ID, `FER_META_RATE, 8'h22, 8'h00, 1'bx);
      rec(ACT_ID, 8'h21, 8'h12, 8'h00, 1'bx);
      drain();
      r0 = 16'($urandom_range(5, 300));
      r1 = 16'($urandom_range(5, 300));
      rng_val[0] <= r0;
      rng_val[1] <= r1;
      rng_val[2] <= 16'hFFFF;
      rng_active <= 6'b000011;
      rec(META_ID, `FER_META_DYNR, 8'h01, 8'h00, 1'bx);
      drain();
      chk("acc scale", (r0 > r1) ? r0 : r1, scale_rng_r[0]);
      chk("acc lsb", host_lsb((r0 > r1) ? r0 : r1), host_lsb(scale_rng_r[0]));
      chk("gyr scale", `FER_RNG_GYR, scale_rng_r[1]);
      meta_en[2] <= 1'b0;
      pulse(1, 8'h05, 1'b0);
      drain();
      chk("framing", 16'h0000, 16'(fer_fifo_sink_i.bad));
      test_done();
   end
endmodule

// file: verilog/fer_byte_sender.sv
// shifts one whole record into the fifo write port
`timescale 1ns/1ps
module fer_byte_sender
   import fer_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst,
   fer_rec_if.snk         rec,
   input  wire logic      fifo_ready,
   output fer_byte_t      fifo_data_r,
   output logic           fifo_valid_r,
   output logic           fifo_first_r,
   output logic           fifo_last_r,
   output logic           fifo_wake_r
);
   fer_rec_t   buf_r;
   logic [3:0] idx_r;
   logic [3:0] len_r;

   assign rec.busy = fifo_valid_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         buf_r        <= '0;
         idx_r        <= 4'h0;
         len_r        <= 4'h0;
         fifo_data_r  <= 8'h00;
         fifo_valid_r <= 1'b0;
         fifo_first_r <= 1'b0;
         fifo_last_r  <= 1'b0;
         fifo_wake_r  <= 1'b0;
      end else if (!fifo_valid_r && rec.load) begin
         buf_r        <= rec.bytes;
         len_r        <= rec.len;
         idx_r        <= 4'h1;
         fifo_data_r  <= rec.bytes[0];
         fifo_valid_r <= 1'b1;
         fifo_first_r <= 1'b1;
         fifo_last_r  <= (rec.len == 4'h1);
         fifo_wake_r  <= rec.wake;
      end else if (fifo_valid_r && fifo_ready) begin
         fifo_first_r <= 1'b0;
         if (idx_r == len_r) begin
            fifo_valid_r <= 1'b0;
            fifo_last_r  <= 1'b0;
         end else begin
            fifo_data_r <= buf_r[idx_r];
            fifo_last_r <= (idx_r + 4'h1 == len_r);
            idx_r       <= idx_r + 4'h1;
         end
      end
   end

   property p_hold_stall;
      @(posedge clk_sys) disable iff (rst)
      fifo_valid_r && !fifo_ready |=> fifo_valid_r && $stable(fifo_data_r) && $stable(fifo_first_r);
   endproperty
   a_hold_stall: assert property (p_hold_stall) else $error("record byte changed under stall");
endmodule

// file: verilog/fer_encoder.sv
// event record encoder for the host fifo
`timescale 1ns/1ps
// Functional notes
// - activity record is written only when some activity start or end bit changes.
// - low byte bits 0..5 flag end of six activities; bits 6,7 zero.
// - high byte bits 8..13 flag start of six activities; bits 14,15 zero.
// - debug records go only to the non-wake fifo, first byte 245.
// - second debug byte bits 0..5 hold payload count, zero to twelve.
// - second debug byte bit 6 is binary flag; bit 7 zero.
// - payload in bytes 2..13; long messages split into twelve-byte records.
// - motion groups scale from the largest active virtual sensor range.
// - accelerometer group defaults to 4g range.
// - gyro defaults to 2000 dps, magnetometer to 1000 uT.
// - each meta event has its own enable and interrupt enable; the initialized event is sent even with its meta_en bit clear.
// - initialized meta event is the first record; host waits for it.
// - every flush request yields a flush-complete record with sensor type; requests pending together give one record, none with meta_en[1] clear.
// - flush hands buffered data to the host, never discards it.
// - rate set or changed yields sample-rate-changed record with sensor type.
// - overflow record carries a saturating lost-byte count.
module fer_encoder
   import fer_pkg::*;
#(
   parameter int        NV        = 2,
   parameter fer_byte_t META_ID   = 8'hFE,
   parameter fer_byte_t ACT_ID    = 8'h1F,
   parameter fer_byte_t ACC_TYPE  = 8'h01,
   parameter fer_byte_t GYR_TYPE  = 8'h10,
   parameter fer_byte_t MAG_TYPE  = 8'h0E
)(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [15:0]       ram_ver,
   input  wire logic [16:0]       meta_en,
   input  wire logic [16:0]       meta_int_en,
   input  wire logic              act_valid,
   input  wire logic [5:0]        act_end,
   input  wire logic [5:0]        act_start,
   input  wire logic              dbg_valid,
   input  wire fer_pkg::fer_byte_t dbg_byte,
   input  wire logic              dbg_last,
   input  wire logic              dbg_bin,
   output logic                   dbg_ready_r,
   input  wire logic              flush_req,
   input  wire fer_pkg::fer_byte_t flush_sensor,
   input  wire logic              flush_wake,
   input  wire logic              rate_chg,
   input  wire fer_pkg::fer_byte_t rate_sensor,
   input  wire logic              ovf_valid,
   input  wire fer_pkg::fer_byte_t ovf_bytes,
   input  wire logic [3*NV-1:0]   rng_active,
   input  wire fer_pkg::fer_rng_t rng_val [3*NV],
   output fer_pkg::fer_rng3_t     scale_rng_r,
   input  wire logic              fifo_ready,
   output fer_pkg::fer_byte_t     fifo_data_r,
   output logic                   fifo_valid_r,
   output logic                   fifo_first_r,
   output logic                   fifo_last_r,
   output logic                   fifo_wake_r,
   output logic                   host_irq_r,
   output logic                   init_done_r,
   output logic                   flush_xfer_r
);
   import fer_pkg::*;
   `include "fer_cfg.svh"

   if (NV < 1 || NV > 8) begin : g_chk
      $error("NV out of range");
   end

   fer_rec_if  rec ();
   fer_state_t state_r;
   fer_kind_t  kind_r;
   fer_rec_t   rec_bytes_r;
   logic [3:0] rec_len_r;
   logic       rec_wake_r;
   logic       rec_irq_r;

   logic       flsh_pend_r, rate_pend_r, ovf_pend_r, act_pend_r, dbg_pend_r;
   logic [2:0] dynr_pend_r;
   fer_byte_t  flsh_type_r, rate_type_r;
   logic       flsh_wake_r;
   fer_rng_t   ovf_cnt_r;
   logic [5:0] act_end_r, act_beg_r;
   fer_byte_t  dbg_buf_r [12];
   logic [3:0] dbg_cnt_r;
   logic       dbg_bin_r;

   // pick outcome
   logic       take;
   fer_kind_t  take_kind;
   logic [4:0] take_meta;
   fer_rng3_t  rng_nxt;

   function automatic fer_rng_t max_rng(input int g, input fer_rng_t dflt);
      fer_rng_t m;
      logic     any;
      m   = 16'h0000;
      any = 1'b0;
      for (int i = 0; i < NV; i++) begin
         if (rng_active[g*NV+i] && rng_val[g*NV+i] >= m) begin
            m   = rng_val[g*NV+i];
            any = 1'b1;
         end
      end
      return any ? m : dflt;
   endfunction

   always_comb begin
      rng_nxt[0] = max_rng(0, `FER_RNG_ACC);
      rng_nxt[1] = max_rng(1, `FER_RNG_GYR);
      rng_nxt[2] = max_rng(2, `FER_RNG_MAG);
   end

   always_comb begin
      take      = (state_r == FER_ST_IDLE);
      take_kind = FER_K_INIT;
      take_meta = 5'(`FER_META_INIT);
      if (!init_done_r) begin
         take_kind = FER_K_INIT;
      end else if (ovf_pend_r) begin
         take_kind = FER_K_OVF;
         take_meta = 5'(`FER_META_OVF);
      end else if (flsh_pend_r) begin
         take_kind = FER_K_FLSH;
         take_meta = 5'(`FER_META_FLUSH);
      end else if (rate_pend_r) begin
         take_kind = FER_K_RATE;
         take_meta = 5'(`FER_META_RATE);
      end else if (|dynr_pend_r) begin
         take_kind = FER_K_DYNR;
         take_meta = 5'(`FER_META_DYNR);
      end else if (act_pend_r) begin
         take_kind = FER_K_ACT;
      end else if (dbg_pend_r) begin
         take_kind = FER_K_DBG;
      end else begin
         take = 1'b0;
      end
   end

   wire       is_meta  = take_kind inside {FER_K_INIT, FER_K_OVF, FER_K_FLSH, FER_K_RATE, FER_K_DYNR};
   wire       meta_on  = take_kind == FER_K_INIT || meta_en[take_meta];
   wire [1:0] dynr_sel = dynr_pend_r[0] ? 2'd0 : (dynr_pend_r[1] ? 2'd1 : 2'd2);
   wire [2:0] dynr_clr = (take && take_kind == FER_K_DYNR) ? (3'b001 << dynr_sel) : 3'b000;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r     <= FER_ST_IDLE;
         kind_r      <= FER_K_INIT;
         rec_bytes_r <= '0;
         rec_len_r   <= 4'h0;
         rec_wake_r  <= 1'b0;
         rec_irq_r   <= 1'b0;
         init_done_r <= 1'b0;
      end else begin
         unique case (state_r)
            FER_ST_IDLE: begin
               if (take && (!is_meta || meta_on)) begin
                  state_r     <= FER_ST_LOAD;
                  kind_r      <= take_kind;
                  rec_bytes_r <= '0;
                  rec_wake_r  <= 1'b0;
                  rec_irq_r   <= is_meta && meta_int_en[take_meta];
                  if (is_meta) begin
                     rec_len_r      <= `FER_META_LEN;
                     rec_bytes_r[0] <= META_ID;
                     rec_bytes_r[1] <= {3'b000, take_meta};
                  end
                  unique case (take_kind)
                     FER_K_INIT: begin
                        rec_bytes_r[2] <= ram_ver[7:0];
                        rec_bytes_r[3] <= ram_ver[15:8];
                        init_done_r    <= 1'b1;
                     end
                     FER_K_OVF: begin
                        rec_bytes_r[2] <= ovf_cnt_r[7:0];
                        rec_bytes_r[3] <= ovf_cnt_r[15:8];
                     end
                     FER_K_FLSH: begin
                        rec_bytes_r[2] <= flsh_type_r;
                        rec_wake_r     <= flsh_wake_r;
                     end
                     FER_K_RATE: rec_bytes_r[2] <= rate_type_r;
                     FER_K_DYNR: rec_bytes_r[2] <= (dynr_sel == 2'd0) ? ACC_TYPE :
                                                   (dynr_sel == 2'd1) ? GYR_TYPE : MAG_TYPE;
                     FER_K_ACT: begin
                        rec_len_r      <= `FER_ACT_LEN;
                        rec_bytes_r[0] <= ACT_ID;
                        rec_bytes_r[1] <= {2'b00, act_end_r};
                        rec_bytes_r[2] <= {2'b00, act_beg_r};
                     end
                     FER_K_DBG: begin
                        rec_len_r      <= dbg_cnt_r + 4'h2;
                        rec_bytes_r[0] <= `FER_ID_DEBUG;
                        rec_bytes_r[1] <= {1'b0, dbg_bin_r, 2'b00, dbg_cnt_r};
                        for (int i = 0; i < 12; i++) begin
                           rec_bytes_r[i+2] <= dbg_buf_r[i];
                        end
                     end
                  endcase
               end
            end
            FER_ST_LOAD: state_r <= FER_ST_SEND;
            FER_ST_SEND: if (!rec.busy) state_r <= FER_ST_IDLE;
            default:     state_r <= FER_ST_IDLE;
         endcase
      end
   end

   assign rec.load  = (state_r == FER_ST_LOAD);
   assign rec.len   = rec_len_r;
   assign rec.bytes = rec_bytes_r;
   assign rec.wake  = rec_wake_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         host_irq_r   <= 1'b0;
         flush_xfer_r <= 1'b0;
      end else begin
         host_irq_r   <= rec.load && rec_irq_r;
         flush_xfer_r <= take && take_kind == FER_K_FLSH;
      end
   end

   // pending meta sources; a new event wins over the clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flsh_pend_r <= 1'b0;
         flsh_type_r <= 8'h00;
         flsh_wake_r <= 1'b0;
         rate_pend_r <= 1'b0;
         rate_type_r <= 8'h00;
         ovf_pend_r  <= 1'b0;
         ovf_cnt_r   <= 16'h0000;
         dynr_pend_r <= 3'b000;
         scale_rng_r <= {`FER_RNG_MAG, `FER_RNG_GYR, `FER_RNG_ACC};
      end else begin
         flsh_pend_r <= flush_req | (flsh_pend_r & ~(take && take_kind == FER_K_FLSH));
         if (flush_req) begin
            flsh_type_r <= flush_sensor;
            flsh_wake_r <= flush_wake;
         end
         rate_pend_r <= rate_chg | (rate_pend_r & ~(take && take_kind == FER_K_RATE));
         if (rate_chg) rate_type_r <= rate_sensor;
         ovf_pend_r <= ovf_valid | (ovf_pend_r & ~(take && take_kind == FER_K_OVF));
         if (ovf_valid) begin
            logic [16:0] sum;
            sum = {1'b0, (take && take_kind == FER_K_OVF) ? 16'h0000 : ovf_cnt_r} + {9'h000, ovf_bytes};
            ovf_cnt_r <= sum[16] ? `FER_CNT_MAX : sum[15:0];
         end else if (take && take_kind == FER_K_OVF) begin
            ovf_cnt_r <= 16'h0000;
         end
         scale_rng_r <= rng_nxt;
         for (int g = 0; g < 3; g++) begin
            dynr_pend_r[g] <= (rng_nxt[g] != scale_rng_r[g]) | (dynr_pend_r[g] & ~dynr_clr[g]);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         act_pend_r <= 1'b0;
         act_end_r  <= 6'h00;
         act_beg_r  <= 6'h00;
      end else begin
         logic tk;
         logic nw;
         tk = take && take_kind == FER_K_ACT;
         nw = act_valid && (|{act_end, act_start});
         act_pend_r <= nw | (act_pend_r & ~tk);
         act_end_r  <= (tk ? 6'h00 : act_end_r) | (nw ? act_end : 6'h00);
         act_beg_r  <= (tk ? 6'h00 : act_beg_r) | (nw ? act_start : 6'h00);
      end
   end

   // debug byte gathering, split at twelve bytes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dbg_pend_r  <= 1'b0;
         dbg_cnt_r   <= 4'h0;
         dbg_bin_r   <= 1'b0;
         dbg_ready_r <= 1'b0;
         for (int i = 0; i < 12; i++) dbg_buf_r[i] <= 8'h00;
      end else begin
         logic pend_nxt;
         pend_nxt = dbg_pend_r && !(take && take_kind == FER_K_DBG);
         if (!dbg_pend_r && dbg_valid && dbg_ready_r) begin
            dbg_buf_r[dbg_cnt_r] <= dbg_byte;
            dbg_cnt_r            <= dbg_cnt_r + 4'h1;
            dbg_bin_r            <= dbg_bin;
            pend_nxt             = dbg_last || dbg_cnt_r + 4'h1 == `FER_DBG_MAX;
         end else if (dbg_pend_r && !pend_nxt) begin
            dbg_cnt_r <= 4'h0;
         end
         dbg_pend_r  <= pend_nxt;
         dbg_ready_r <= !pend_nxt;
      end
   end

   fer_byte_sender u_send (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .rec          (rec),
      .fifo_ready   (fifo_ready),
      .fifo_data_r  (fifo_data_r),
      .fifo_valid_r (fifo_valid_r),
      .fifo_first_r (fifo_first_r),
      .fifo_last_r  (fifo_last_r),
      .fifo_wake_r  (fifo_wake_r)
   );

   wire ld = rec.load;

   property p_init_first;
      @(posedge clk_sys) disable iff (rst)
      ld && kind_r == FER_K_INIT |-> rec_bytes_r[1] == `FER_META_INIT && rec_bytes_r[0] == META_ID;
   endproperty
   a_init_first: assert property (p_init_first) else $error("first record not initialized event");

   property p_init_gate;
      @(posedge clk_sys) disable iff (rst)
      !init_done_r |-> !ld || kind_r == FER_K_INIT;
   endproperty
   a_init_gate: assert property (p_init_gate) else $error("record before initialized event");

   property p_act_fmt;
      @(posedge clk_sys) disable iff (rst)
      ld && kind_r == FER_K_ACT |-> rec_len_r == 4'h3 && rec_bytes_r[1][7:6] == 2'b00
         && rec_bytes_r[2][7:6] == 2'b00 && (|{rec_bytes_r[1], rec_bytes_r[2]});
   endproperty
   a_act_fmt: assert property (p_act_fmt) else $error("bad activity record");

   property p_dbg_fmt;
      @(posedge clk_sys) disable iff (rst)
      ld && kind_r == FER_K_DBG |-> rec_bytes_r[0] == 8'hF5 && !rec_wake_r && !rec_bytes_r[1][7]
         && rec_bytes_r[1][3:0] <= 4'hC && rec_len_r == rec_bytes_r[1][3:0] + 4'h2;
   endproperty
   a_dbg_fmt: assert property (p_dbg_fmt) else $error("bad debug record");

   sequence s_flush_take;
      take && take_kind == FER_K_FLSH && meta_en[1];
   endsequence
   sequence s_flush_out;
      ##1 flush_xfer_r && ld && rec_bytes_r[1] == 8'h01 && rec_bytes_r[2] == $past(flsh_type_r);
   endsequence
   property p_flush;
      @(posedge clk_sys) disable iff (rst)
      s_flush_take |-> s_flush_out;
   endproperty
   a_flush: assert property (p_flush) else $error("flush record or transfer missing");

   property p_irq;
      @(posedge clk_sys) disable iff (rst)
      ld && rec_irq_r |=> host_irq_r ##1 !host_irq_r;
   endproperty
   a_irq: assert property (p_irq) else $error("meta interrupt not raised");

   property p_ovf_sat;
      @(posedge clk_sys) disable iff (rst)
      ovf_cnt_r == 16'hFFFF && ovf_valid && !(take && take_kind == FER_K_OVF) |=> ovf_cnt_r == 16'hFFFF;
   endproperty
   a_ovf_sat: assert property (p_ovf_sat) else $error("loss count wrapped");

   property p_scale_dflt;
      @(posedge clk_sys) disable iff (rst)
      rng_active[NV-1:0] == '0 |=> scale_rng_r[0] == 16'h0004;
   endproperty
   a_scale_dflt: assert property (p_scale_dflt) else $error("accel default range wrong");
endmodule
